// >>> dsg_defines.svh
`ifndef DSG_DEFINES_SVH
`define DSG_DEFINES_SVH

// register byte offsets from the system-control base
`define DSG_BASE_ADDR        32'h400fe000
`define DSG_OFF_SOFT_RESET   12'h040
`define DSG_OFF_SLEEP_GATE   12'h118
`define DSG_OFF_DEEP_GATE    12'h128
`define DSG_OFF_RUN_GATE     12'h108
`define DSG_OFF_RUN_CFG      12'h060
`define DSG_OFF_CAP_ONE      12'h010
`define DSG_OFF_IRQ_STATUS   12'h1f0
`define DSG_OFF_IRQ_MASK     12'h1f4

// gate register layout
`define DSG_GATE_MASK        32'h00012_0ff
`define DSG_GATE_USB_BIT     16
`define DSG_GATE_DMA_BIT     13
`define DSG_GATE_PORT_HI     7

// soft reset register layout
`define DSG_RST_MASK         32'h01010048
`define DSG_RST_CAN_BIT      24
`define DSG_RST_CONV_BIT     16
`define DSG_RST_LOWPWR_BIT   6
`define DSG_RST_WDOG_BIT     3

// run clock config: auto gating select
`define DSG_CFG_ACG_BIT      27
`define DSG_CFG_MASK         32'h08000000

// interrupt status bits
`define DSG_IRQ_FAULT_BIT    0
`define DSG_IRQ_MODE_BIT     1
`define DSG_IRQ_MASK         32'h00000003

`define DSG_RESET_VALUE      32'h00000000
`define DSG_CAP_DEFAULT      32'h01010048

`endif

// >>> dsg_pkg.sv
package dsg_pkg;

  // power mode of the system
  typedef enum logic [2:0]
  {
    DSG_RUN   = 3'b001,
    DSG_SLEEP = 3'b010,
    DSG_DEEP  = 3'b100
  } dsg_mode_e;

  // apb slave phase
  typedef enum logic [1:0]
  {
    DSG_IDLE   = 2'b01,
    DSG_ACCESS = 2'b10
  } dsg_apb_e;

endpackage

// >>> dsg_gate_sel.sv
`timescale 1ns/100ps
`include "dsg_defines.svh"

// picks the active gate word for the current power mode
module dsg_gate_sel
(
  input  wire logic [31:0]      run_gate_in,
  input  wire logic [31:0]      sleep_gate_in,
  input  wire logic [31:0]      deep_gate_in,
  input  wire logic             auto_gating_select_in,
  input  wire dsg_pkg::dsg_mode_e mode_in,
  output logic      [31:0]      gate_out
);

  // mode dependent selection
  always_comb
  begin
    case (mode_in)
      dsg_pkg::DSG_RUN:   gate_out = run_gate_in;
      dsg_pkg::DSG_SLEEP: gate_out = auto_gating_select_in ? sleep_gate_in : run_gate_in;
      dsg_pkg::DSG_DEEP:  gate_out = auto_gating_select_in ? deep_gate_in : run_gate_in;
      default:            gate_out = run_gate_in;
    endcase
  end

endmodule

// >>> dsg_clock_reset_ctrl.sv
`timescale 1ns/100ps
`include "dsg_defines.svh"

module dsg_clock_reset_ctrl
#(
  parameter logic [31:0] CAP_ONE = `DSG_CAP_DEFAULT
)
(
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  // apb slave
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [31:0]      paddr_in,
  input  wire logic [31:0]      pwdata_in,
  input  wire logic [3:0]       pstrb_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  // power mode of the system
  input  wire logic             sleep_req_in,
  input  wire logic             deep_sleep_in,
  // peripheral access monitor
  input  wire logic             unit_access_in,
  input  wire logic [3:0]       unit_index_in,
  output logic                  unit_fault_out,
  // clock enables and resets to units, and the interrupt
  output logic                  usb_unit_clock_gate_out,
  output logic                  micro_dma_clock_gate_out,
  output logic      [7:0]       port_clock_gate_out,
  output logic                  can_unit_reset_out,
  output logic                  converter_reset_out,
  output logic                  low_power_module_reset_out,
  output logic                  watchdog_unit_reset_out,
  output logic                  irq_out
);

  logic [31:0]        run_gate_two_q;
  logic [31:0]        sleep_gate_two_q;
  logic [31:0]        deep_sleep_gate_two_q;
  logic [31:0]        soft_reset_zero_q;
  logic [31:0]        run_clock_config_q;
  logic [31:0]        irq_status_q;
  logic [31:0]        irq_mask_q;
  logic [31:0]        active_gate;
  logic [31:0]        wmask;
  logic [31:0]        wdata_m;
  logic [31:0]        rdata_d;
  logic [31:0]        prdata_q;
  logic               slverr_q;
  logic               unit_fault_q;
  logic               fault_ev;
  logic               mode_ev;
  logic               hit;
  logic               wr_en;
  logic               rd_en;
  logic               unit_on;
  logic [11:0]        offs;
  dsg_pkg::dsg_mode_e mode;
  dsg_pkg::dsg_mode_e mode_q;
  dsg_pkg::dsg_apb_e  apb_q;

  assign offs = paddr_in[11:0];

  // current power mode, deep-sleep wins
  always_comb
  begin
    if (deep_sleep_in)
      mode = dsg_pkg::DSG_DEEP;
    else if (sleep_req_in)
      mode = dsg_pkg::DSG_SLEEP;
    else
      mode = dsg_pkg::DSG_RUN;
  end

  // active gate word for this mode
  dsg_gate_sel u_gate_sel
  (
    .run_gate_in           (run_gate_two_q),
    .sleep_gate_in         (sleep_gate_two_q),
    .deep_gate_in          (deep_sleep_gate_two_q),
    .auto_gating_select_in (run_clock_config_q[`DSG_CFG_ACG_BIT]),
    .mode_in               (mode),
    .gate_out              (active_gate)
  );

  // unit clock enables from the active gate
  assign usb_unit_clock_gate_out  = active_gate[`DSG_GATE_USB_BIT];
  assign micro_dma_clock_gate_out = active_gate[`DSG_GATE_DMA_BIT];
  assign port_clock_gate_out      = active_gate[`DSG_GATE_PORT_HI:0];

  // unit resets held while bit set
  assign can_unit_reset_out         = soft_reset_zero_q[`DSG_RST_CAN_BIT];
  assign converter_reset_out        = soft_reset_zero_q[`DSG_RST_CONV_BIT];
  assign low_power_module_reset_out = soft_reset_zero_q[`DSG_RST_LOWPWR_BIT];
  assign watchdog_unit_reset_out    = soft_reset_zero_q[`DSG_RST_WDOG_BIT];

  // is the addressed unit clocked: 0..7 ports, 8 dma, 9 usb
  always_comb
  begin
    case (unit_index_in)
      4'h8:    unit_on = active_gate[`DSG_GATE_DMA_BIT];
      4'h9:    unit_on = active_gate[`DSG_GATE_USB_BIT];
      default: unit_on = (unit_index_in < 4'h8) ? active_gate[unit_index_in[2:0]] : 1'b0;
    endcase
  end

  assign fault_ev = unit_access_in && !unit_on;

  // fault answer to the unit bus, one cycle after the access
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      unit_fault_q <= 1'b0;
    else
      unit_fault_q <= fault_ev;
  end
  assign unit_fault_out = unit_fault_q;

  // apb phase tracking, single wait-free access
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      apb_q <= dsg_pkg::DSG_IDLE;
    else
    begin
      case (apb_q)
        dsg_pkg::DSG_IDLE:   apb_q <= (psel_in && !penable_in) ? dsg_pkg::DSG_ACCESS : dsg_pkg::DSG_IDLE;
        dsg_pkg::DSG_ACCESS: apb_q <= dsg_pkg::DSG_IDLE;
        default:             apb_q <= dsg_pkg::DSG_IDLE;
      endcase
    end
  end

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;

  // byte strobe mask
  assign wmask   = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  assign wdata_m = pwdata_in & wmask;

  // address decode for mapped offsets
  always_comb
  begin
    case (offs)
      `DSG_OFF_SOFT_RESET, `DSG_OFF_SLEEP_GATE, `DSG_OFF_DEEP_GATE, `DSG_OFF_RUN_GATE,
      `DSG_OFF_RUN_CFG, `DSG_OFF_CAP_ONE, `DSG_OFF_IRQ_STATUS, `DSG_OFF_IRQ_MASK:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
  end

  // gate registers, reserved bits kept zero
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      run_gate_two_q        <= `DSG_RESET_VALUE;
      sleep_gate_two_q      <= `DSG_RESET_VALUE;
      deep_sleep_gate_two_q <= `DSG_RESET_VALUE;
    end
    else if (wr_en)
    begin
      if (offs == `DSG_OFF_RUN_GATE)
        run_gate_two_q <= ((run_gate_two_q & ~wmask) | wdata_m) & `DSG_GATE_MASK;
      if (offs == `DSG_OFF_SLEEP_GATE)
        sleep_gate_two_q <= ((sleep_gate_two_q & ~wmask) | wdata_m) & `DSG_GATE_MASK;
      if (offs == `DSG_OFF_DEEP_GATE)
        deep_sleep_gate_two_q <= ((deep_sleep_gate_two_q & ~wmask) | wdata_m) & `DSG_GATE_MASK;
    end
  end

  // soft reset register masked by capabilities
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      soft_reset_zero_q <= `DSG_RESET_VALUE;
    else if (wr_en && offs == `DSG_OFF_SOFT_RESET)
      soft_reset_zero_q <= ((soft_reset_zero_q & ~wmask) | wdata_m) & `DSG_RST_MASK & CAP_ONE;
  end

  // run clock config, only auto gating bit held
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      run_clock_config_q <= `DSG_RESET_VALUE;
    else if (wr_en && offs == `DSG_OFF_RUN_CFG)
      run_clock_config_q <= ((run_clock_config_q & ~wmask) | wdata_m) & `DSG_CFG_MASK;
  end

  // mode change event tracking
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      mode_q <= dsg_pkg::DSG_RUN;
    else
      mode_q <= mode;
  end
  assign mode_ev = (mode_q != mode);

  // sticky status, set wins over write-one clear
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      irq_status_q <= `DSG_RESET_VALUE;
    else
    begin
      irq_status_q <= ((wr_en && offs == `DSG_OFF_IRQ_STATUS) ? (irq_status_q & ~wdata_m) : irq_status_q)
                      | {30'h0, mode_ev, fault_ev};
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      irq_mask_q <= `DSG_RESET_VALUE;
    else if (wr_en && offs == `DSG_OFF_IRQ_MASK)
      irq_mask_q <= ((irq_mask_q & ~wmask) | wdata_m) & `DSG_IRQ_MASK;
  end

  assign irq_out = |(irq_status_q & irq_mask_q);

  // read mux
  always_comb
  begin
    case (offs)
      `DSG_OFF_SOFT_RESET: rdata_d = soft_reset_zero_q;
      `DSG_OFF_SLEEP_GATE: rdata_d = sleep_gate_two_q;
      `DSG_OFF_DEEP_GATE:  rdata_d = deep_sleep_gate_two_q;
      `DSG_OFF_RUN_GATE:   rdata_d = run_gate_two_q;
      `DSG_OFF_RUN_CFG:    rdata_d = run_clock_config_q;
      `DSG_OFF_CAP_ONE:    rdata_d = CAP_ONE;
      `DSG_OFF_IRQ_STATUS: rdata_d = irq_status_q;
      `DSG_OFF_IRQ_MASK:   rdata_d = irq_mask_q;
      default:             rdata_d = 32'h00000000;
    endcase
  end

  // read data and error registered in setup phase
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end
    else if (psel_in && !penable_in)
    begin
      prdata_q <= rd_en ? rdata_d : 32'h00000000;
      slverr_q <= !hit;
    end
  end

  assign prdata_out  = prdata_q;
  assign pready_out  = 1'b1;
  // error only in a tracked access phase
  assign pslverr_out = (apb_q == dsg_pkg::DSG_ACCESS) && psel_in && penable_in && slverr_q;

endmodule

// >>> dsg_ctrl_asserts.sv
`timescale 1ns/100ps
// watches the register slave, the access monitor and the unit controls
module dsg_ctrl_asserts
#(
  parameter logic [31:0] CAP_ONE = 32'h01010048
)
(
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pslverr_out,
  input wire logic        sleep_req_in,
  input wire logic        deep_sleep_in,
  input wire logic        unit_access_in,
  input wire logic [3:0]  unit_index_in,
  input wire logic        unit_fault_out,
  input wire logic        usb_unit_clock_gate_out,
  input wire logic        micro_dma_clock_gate_out,
  input wire logic [7:0]  port_clock_gate_out,
  input wire logic        can_unit_reset_out,
  input wire logic        converter_reset_out,
  input wire logic        low_power_module_reset_out,
  input wire logic        watchdog_unit_reset_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // decoded access phase and gathered unit controls
  wire logic        acc = psel_in && penable_in;
  wire logic        wr  = acc && pwrite_in;
  wire logic        rd  = acc && !pwrite_in;
  wire logic [11:0] off = paddr_in[11:0];
  wire logic [9:0]  gts = {usb_unit_clock_gate_out, micro_dma_clock_gate_out, port_clock_gate_out};
  wire logic [3:0]  rst = {can_unit_reset_out, converter_reset_out, low_power_module_reset_out, watchdog_unit_reset_out};
  wire logic [3:0]  cap = {CAP_ONE[24], CAP_ONE[16], CAP_ONE[6], CAP_ONE[3]};
  wire logic        map = off inside {12'h040, 12'h118, 12'h128, 12'h108, 12'h060, 12'h010, 12'h1f0, 12'h1f4};
  wire logic        on  = unit_index_in < 4'h8 ? port_clock_gate_out[unit_index_in[2:0]] :
                          unit_index_in == 4'h8 ? gts[8] : unit_index_in == 4'h9 && gts[9];

  a_fault_gated : assert property (unit_access_in |=> unit_fault_out == !$past(on))
    else $error("fault pulse disagrees with gate");
  a_fault_quiet : assert property (!unit_access_in |=> !unit_fault_out)
    else $error("fault pulse without access");
  a_reset_zero : assert property ($fell(reset_in) |-> gts == 10'h0 && rst == 4'h0)
    else $error("controls not clear after reset");
  a_gate_hold : assert property (!wr ##1 $stable(sleep_req_in) && $stable(deep_sleep_in) |-> $stable(gts))
    else $error("gate moved without cause");
  a_rst_write : assert property (wr && off == 12'h040 && pstrb_in == 4'hf |=>
    rst == ($past({pwdata_in[24], pwdata_in[16], pwdata_in[6], pwdata_in[3]}) & cap))
    else $error("reset outputs differ from write");
  a_rst_hold : assert property (!(wr && off == 12'h040) |=> $stable(rst))
    else $error("reset outputs moved without write");
  a_bad_offset : assert property (acc |-> pslverr_out == !map)
    else $error("error response wrong for offset");
  a_gate_rsvd : assert property (rd && off == 12'h128 |-> (prdata_out & 32'hfffedf00) == 32'h0)
    else $error("reserved gate bits read nonzero");
  a_rst_rsvd : assert property (rd && off == 12'h040 |-> (prdata_out & ~CAP_ONE) == 32'h0)
    else $error("absent reset bits read nonzero");

  c_fault : cover property (unit_fault_out);
  c_deep : cover property (deep_sleep_in && gts != 10'h0);
  c_rst : cover property (wr && off == 12'h040);
endmodule

bind dsg_clock_reset_ctrl dsg_ctrl_asserts #(.CAP_ONE(CAP_ONE)) u_chk (.*);

// >>> dsg_unit_model.sv
`timescale 1ns/100ps
// peripheral side: one access per request, index inverted while idle
module dsg_unit_model
(
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [3:0] idx_in,
  output logic            unit_access_out,
  output logic      [3:0] unit_index_out
);
  // registered request, idle index shows the inverse of the request
  always @(posedge clk_in)
  begin
    unit_access_out <= go_in;
    unit_index_out  <= go_in ? idx_in : ~idx_in;
  end
endmodule

// >>> tb_dsg_clock_reset_ctrl.sv
`timescale 1ns/100ps
`include "dsg_defines.svh"
// drives registers and unit traffic, checks against queued notes
module tb_dsg_clock_reset_ctrl;
  logic        sys_clk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, go, acc_d;
  logic        sleep_req_in, deep_sleep_in, unit_access_in, unit_fault_out, irq_out;
  logic        usb_unit_clock_gate_out, micro_dma_clock_gate_out, can_unit_reset_out;
  logic        converter_reset_out, low_power_module_reset_out, watchdog_unit_reset_out;
  logic [31:0] paddr_in, pwdata_in, prdata_out, r, g, rg, sg, dg;
  logic [3:0]  pstrb_in, unit_index_in, gidx;
  logic [7:0]  port_clock_gate_out;
  logic [11:0] a;
  logic [32:0] nt, nq[$];
  logic        fq[$];
  int          n_fail, checked;
  // converter left out so capability masking is exercised
  localparam logic [31:0] CAP = 32'h01000048;

  dsg_clock_reset_ctrl #(.CAP_ONE(CAP)) dut
  (
    .sys_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
    .prdata_out, .pready_out, .pslverr_out, .sleep_req_in, .deep_sleep_in, .unit_access_in,
    .unit_index_in, .unit_fault_out, .usb_unit_clock_gate_out, .micro_dma_clock_gate_out,
    .port_clock_gate_out, .can_unit_reset_out, .converter_reset_out, .low_power_module_reset_out,
    .watchdog_unit_reset_out, .irq_out
  );
  dsg_unit_model um (.clk_in(sys_clk_in), .go_in(go), .idx_in(gidx), .unit_access_out(unit_access_in),
    .unit_index_out(unit_index_in));

  // 125 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    n_fail++;
    tally_and_finish();
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    checked++;
    if (v !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask

  // one apb transfer, note queued for the monitor, one idle edge after
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] e);
    nq.push_back(e);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {20'h400fe, ad};
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0, {1'b0, e});
  endtask

  // one unit access through the partner, fault note queued
  task automatic hit(input logic [3:0] i, input logic e);
    fq.push_back(e);
    go <= 1'b1;
    gidx <= i;
    @(posedge sys_clk_in);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask

  function automatic logic fexp(input logic [3:0] i);
    return i < 4'h8 ? !g[i[2:0]] : i == 4'h8 ? !g[13] : i == 4'h9 ? !g[16] : 1'b1;
  endfunction

  task automatic done(input string s);
    $display("test %s done", s);
    repeat (4) @(posedge sys_clk_in);
  endtask

  // compares each finished transfer and fault slot with its oldest note
  always @(posedge sys_clk_in)
  begin
    if (psel_in && penable_in && pready_out === 1'b1)
    begin
      nt = nq.pop_front();
      chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr_out});
      if (!pwrite_in)
        chk("prdata", nt[31:0], prdata_out);
    end
    if (acc_d)
      chk("fault", {31'h0, fq.pop_front()}, {31'h0, unit_fault_out});
    acc_d <= unit_access_in;
  end

  initial
  begin
    {reset_in, pstrb_in} = 5'h1f;
    {psel_in, penable_in, pwrite_in, sleep_req_in, deep_sleep_in, go} = 6'h00;
    {paddr_in, pwdata_in, gidx} = 68'h0;
    n_fail = 0;
    checked = 0;
    void'($urandom(32'h07b5902f));
    repeat (8) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    rd(12'h040, 32'h0);
    rd(12'h128, 32'h0);
    rd(12'h118, 32'h0);
    g = 32'h0;
    hit(4'h9, 1'b1);
    done("reset");
    for (int k = 0; k < 4; k++)
    begin
      r = k < 2 ? 32'hffffffff : $urandom;
      a = k[0] ? 12'h128 : 12'h118;
      wr(a, r);
      rd(a, r & `DSG_GATE_MASK);
      dg = k[0] ? r & `DSG_GATE_MASK : dg;
      sg = k[0] ? sg : r & `DSG_GATE_MASK;
    end
    wr(12'h128, dg | 32'h00000001);
    dg = dg | 32'h00000001;
    rd(12'h128, dg);
    rg = $urandom & `DSG_GATE_MASK;
    wr(12'h108, rg);
    done("gate layout");
    for (int k = 0; k < 3; k++)
    begin
      r = k == 0 ? 32'hffffffff : k == 1 ? $urandom : 32'h0;
      wr(12'h040, r);
      r = r & `DSG_RST_MASK & CAP;
      rd(12'h040, r);
      chk("resets", {28'h0, r[24], r[16], r[6], r[3]}, {28'h0, can_unit_reset_out, converter_reset_out,
        low_power_module_reset_out, watchdog_unit_reset_out});
    end
    rd(12'h010, CAP);
    done("soft reset");
    for (int m = 0; m < 6; m++)
    begin
      wr(12'h060, {4'h0, m[0], 27'h0});
      sleep_req_in <= m[2:1] == 2'd1;
      deep_sleep_in <= m[2:1] == 2'd2;
      @(posedge sys_clk_in);
      g = !m[0] || m < 2 ? rg : m < 4 ? sg : dg;
      chk("gates", {22'h0, g[16], g[13], g[7:0]}, {22'h0, usb_unit_clock_gate_out,
        micro_dma_clock_gate_out, port_clock_gate_out});
      for (int i = 0; i < 11; i++)
        hit(i[3:0], fexp(i[3:0]));
    end
    sleep_req_in <= 1'b0;
    deep_sleep_in <= 1'b0;
    done("power modes");
    apb(1'b1, 12'h200, 32'hffffffff, {1'b1, 32'h0});
    apb(1'b0, 12'h200, 32'h0, {1'b1, 32'h0});
    done("unmapped");
    wr(12'h1f0, 32'h3);
    wr(12'h1f4, 32'h1);
    chk("irq idle", 32'h0, {31'h0, irq_out});
    hit(4'ha, 1'b1);
    chk("irq set", 32'h1, {31'h0, irq_out});
    rd(12'h1f0, 32'h1);
    wr(12'h1f4, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq_out});
    wr(12'h1f4, 32'h1);
    wr(12'h1f0, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
    done("interrupt");
    tally_and_finish();
  end
endmodule
